// *** hw/pulse_timer_defines.svh ***
// register map, field positions, reset values and codes of the pulse timer control
`ifndef PULSE_TIMER_DEFINES_SVH
`define PULSE_TIMER_DEFINES_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_SHARED 8'h01
`define OFS_WIDE_CTL 8'h02
`define OFS_RELOAD_HI 8'h03
`define OFS_RELOAD_LO 8'h04
`define OFS_PORT_OUT 8'h05
// ---------------------------------------------------------------
// shared control fields
// ---------------------------------------------------------------
`define B_MODE 7
`define B_PINSEL 6
`define B_LOGIC_HI 5
`define B_LOGIC_LO 4
`define B_SUB_HI 3
`define B_SUB_LO 2
`define B_INIT8 1
`define B_INIT16 0
`define B_PORT 0
// ---------------------------------------------------------------
// wide timer control fields
// ---------------------------------------------------------------
`define B_W_ENABLE 7
`define B_W_CAPIE 6
`define B_W_FLAG 5
`define B_W_PRE_HI 3
`define B_W_PRE_LO 2
`define B_W_IE 1
`define B_W_SINGLE 0
`define W_STORE_MASK 8'h4F
// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define SHARED_RST 8'h00
`define WIDE_RST 8'h00
`define RELOAD_RST 8'h00
`define RDATA_IDLE 8'h00
`define SUB_NORMAL 2'h0
`define SUB_PINGPONG 2'h1
`define SUB_FORCE0 2'h2
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2
`define FLT_NONE 2'h0
`define FLT_SHORT 2'h1
`define FLT_LONG 2'h2
`define FLT_SHORT_CYC 4'h4
`define FLT_LONG_CYC 4'h8
`define PRE_DIV2 2'h1
`define PRE_DIV4 2'h2
`define PRE_M1 3'h0
`define PRE_M2 3'h1
`define PRE_M4 3'h3
`define PRE_M8 3'h7
`define CNT_ONE 16'h0001
`define CNT_ZERO 16'h0000
`endif

// *** hw/pulse_timer_pkg.sv ***
// types shared by the pulse timer modules
package pulse_timer_pkg;
	typedef enum logic [1:0] {COMB_AND, COMB_OR, COMB_NOR, COMB_NAND} combine_t;
	typedef enum logic {MODE_XMIT, MODE_DEMOD} mode_t;
	typedef enum logic {CNT_IDLE, CNT_RUN} cnt_state_t;
endpackage

// *** hw/timer_link_if.sv ***
// signals between the control block, the wide counter and the input filter
`timescale 1ns/10ps
interface timer_link_if;
	logic start;
	logic stop;
	logic single;
	logic [15:0] reload;
	logic [1:0] pre_sel;
	logic running;
	logic timeout;
	logic [15:0] count;
	logic raw;
	logic [1:0] flt_sel;
	logic level;
	modport ctl(output start, stop, single, reload, pre_sel, raw, flt_sel,
		input running, timeout, count, level);
	modport cnt(input start, stop, single, reload, pre_sel, output running, timeout, count);
	modport flt(input raw, flt_sel, output level);
endinterface

// *** hw/wide_counter.sv ***
// sixteen-bit down counter with prescaler, reload and single-pass stop
`timescale 1ns/10ps
`include "pulse_timer_defines.svh"
module wide_counter import pulse_timer_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	timer_link_if.cnt lk
);
	cnt_state_t state_ff;
	logic [2:0] pre_ff;
	logic [15:0] count_ff;
	wire [2:0] pre_mask;
	wire tick;
	wire at_end;

	// ---------------------------------------------------------------
	// prescaler tick decode
	// ---------------------------------------------------------------
	assign pre_mask = (lk.pre_sel == `FLT_NONE) ? `PRE_M1 :
		(lk.pre_sel == `PRE_DIV2) ? `PRE_M2 :
		(lk.pre_sel == `PRE_DIV4) ? `PRE_M4 : `PRE_M8;
	assign tick = (state_ff == CNT_RUN) && ((pre_ff & pre_mask) == pre_mask);
	assign at_end = tick && (count_ff <= `CNT_ONE);
	assign lk.timeout = at_end;
	assign lk.running = (state_ff == CNT_RUN);
	assign lk.count = count_ff;

	// load, count down, reload or stop
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= CNT_IDLE;
			pre_ff <= `PRE_M1;
			count_ff <= `CNT_ZERO;
		end else if (lk.start) begin
			state_ff <= CNT_RUN;
			pre_ff <= `PRE_M1;
			count_ff <= lk.reload;
		end else begin
			unique case (state_ff)
				CNT_IDLE: begin
					pre_ff <= `PRE_M1;
				end
				CNT_RUN: begin
					pre_ff <= pre_ff + 3'h1;
					if (lk.stop) begin
						state_ff <= CNT_IDLE;
					end else if (at_end && lk.single) begin
						state_ff <= CNT_IDLE;
						count_ff <= `CNT_ZERO;
					end else if (at_end) begin
						count_ff <= lk.reload;
					end else if (tick) begin
						count_ff <= count_ff - `CNT_ONE;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_count_hold: assert property (!lk.running && !lk.start |=> $stable(count_ff))
		else $error("count moved while disabled");
	a_single_stop: assert property (at_end && lk.single && !lk.start |=> !lk.running)
		else $error("single pass did not stop");
	a_modulo_reload: assert property (at_end && !lk.single && !lk.stop && !lk.start
		|=> lk.running && count_ff == $past(lk.reload))
		else $error("modulo reload missing");
endmodule

// *** hw/glitch_filter.sv ***
// demodulator input synchroniser and selectable glitch filter
`timescale 1ns/10ps
`include "pulse_timer_defines.svh"
module glitch_filter (
	input wire logic clk,
	input wire logic resetn,
	timer_link_if.flt lk
);
	logic sync1_ff;
	logic sync2_ff;
	logic level_ff;
	logic [3:0] run_ff;
	wire [3:0] need;
	wire differs;

	// ---------------------------------------------------------------
	// filter length decode
	// ---------------------------------------------------------------
	assign need = (lk.flt_sel == `FLT_SHORT) ? `FLT_SHORT_CYC : `FLT_LONG_CYC;
	assign differs = (sync2_ff != level_ff);
	assign lk.level = level_ff;

	// two-stage synchroniser for the pin
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= lk.raw;
			sync2_ff <= sync1_ff;
		end
	end

	// with the short or long filter a new level must persist the full length before it is taken; otherwise it passes straight
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			level_ff <= 1'b0;
			run_ff <= 4'h0;
		end else if (lk.flt_sel == `FLT_NONE || lk.flt_sel == 2'h3) begin
			level_ff <= sync2_ff;
			run_ff <= 4'h0;
		end else if (!differs) begin
			run_ff <= 4'h0;
		end else if (run_ff + 4'h1 >= need) begin
			level_ff <= sync2_ff;
			run_ff <= 4'h0;
		end else begin
			run_ff <= run_ff + 4'h1;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// the length in force is the one seen at the edge that moved the level
	a_filter_short: assert property ($past(lk.flt_sel) == `FLT_SHORT && $changed(level_ff)
		|-> $past(sync2_ff, 1) == $past(sync2_ff, 4))
		else $error("short filter passed a glitch");
	a_filter_long: assert property ($past(lk.flt_sel) == `FLT_LONG && $changed(level_ff)
		|-> $past(sync2_ff, 1) == $past(sync2_ff, 8))
		else $error("long filter passed a glitch");
endmodule

// *** hw/pulse_timer_common_control.sv ***
// shared control of the eight- and sixteen-bit pulse timers
`timescale 1ns/10ps
`include "pulse_timer_defines.svh"
module pulse_timer_common_control import pulse_timer_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic narrow_timer_run,
	input wire logic narrow_timer_level,
	input wire logic comparator_demod_pin,
	input wire logic alternate_demod_pin,
	input wire logic global_int_enable,
	output logic combined_output_pin,
	output logic narrow_timer_output,
	output logic wide_timer_output,
	output logic wide_timeout_irq,
	output logic ping_pong_active,
	output logic ping_pong_handoff,
	output logic demod_rise_event,
	output logic demod_fall_event,
	output logic demod_mode
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0] shared_ff;
	logic [7:0] wide_ctl_ff;
	logic [7:0] reload_hi_ff;
	logic [7:0] reload_lo_ff;
	logic port_out_ff;
	logic timeout_flag_ff;
	logic rise_flag_ff;
	logic fall_flag_ff;
	logic prev_level_ff;
	logic wide_lvl_ff;
	logic pingpong_ff;
	logic [7:0] rdata_ff;
	logic pin_ff;
	logic narrow_out_ff;
	logic wide_out_ff;
	logic irq_ff;
	logic handoff_ff;
	logic rise_ev_ff;
	logic fall_ev_ff;

	timer_link_if lk();

	wide_counter u_counter (
		.clk(clk),
		.resetn(resetn),
		.lk(lk.cnt)
	);

	glitch_filter u_filter (
		.clk(clk),
		.resetn(resetn),
		.lk(lk.flt)
	);

	// ---------------------------------------------------------------
	// field decode
	// ---------------------------------------------------------------
	wire mode_t mode = mode_t'(shared_ff[`B_MODE]);
	wire xmit = (mode == MODE_XMIT);
	wire demod = (mode == MODE_DEMOD);
	wire pinsel = shared_ff[`B_PINSEL];
	wire [1:0] logic_fld = shared_ff[`B_LOGIC_HI:`B_LOGIC_LO];
	wire [1:0] sub_fld = shared_ff[`B_SUB_HI:`B_SUB_LO];
	wire init8 = shared_ff[`B_INIT8];
	wire init16 = shared_ff[`B_INIT16];
	wire sub_run = !sub_fld[1]; // normal or ping-pong
	wire sub_force = xmit && sub_fld[1];

	// bus strobes per register
	wire wr_shared = wr && (addr == `OFS_SHARED);
	wire wr_wide = wr && (addr == `OFS_WIDE_CTL);
	wire wr_hi = wr && (addr == `OFS_RELOAD_HI);
	wire wr_lo = wr && (addr == `OFS_RELOAD_LO);
	wire wr_port = wr && (addr == `OFS_PORT_OUT);

	// ---------------------------------------------------------------
	// wide counter control
	// ---------------------------------------------------------------
	assign lk.start = wr_wide && wdata[`B_W_ENABLE] && !lk.running;
	assign lk.stop = wr_wide && !wdata[`B_W_ENABLE];
	assign lk.single = wide_ctl_ff[`B_W_SINGLE];
	assign lk.reload = {reload_hi_ff, reload_lo_ff};
	assign lk.pre_sel = wide_ctl_ff[`B_W_PRE_HI:`B_W_PRE_LO];

	// ---------------------------------------------------------------
	// demodulator input path
	// ---------------------------------------------------------------
	assign lk.raw = pinsel ? alternate_demod_pin : comparator_demod_pin;
	assign lk.flt_sel = demod ? sub_fld : `FLT_NONE;

	// edge detection on the filtered level
	wire lvl_rise = lk.level && !prev_level_ff;
	wire lvl_fall = !lk.level && prev_level_ff;
	wire rise_en = demod && (logic_fld == `EDGE_RISE || logic_fld == `EDGE_BOTH);
	wire fall_en = demod && (logic_fld == `EDGE_FALL || logic_fld == `EDGE_BOTH);
	wire rise_set = rise_en && lvl_rise;
	wire fall_set = fall_en && lvl_fall;
	wire rise_clr = wr_shared && demod && wdata[`B_INIT8];
	wire fall_clr = wr_shared && demod && wdata[`B_INIT16];

	// flags: a new edge wins over a clear in the same cycle
	wire nxt_rise_flag = rise_set || (rise_flag_ff && !rise_clr);
	wire nxt_fall_flag = fall_set || (fall_flag_ff && !fall_clr);
	wire tclr = wr_wide && wdata[`B_W_FLAG];
	wire nxt_timeout_flag = lk.timeout || (timeout_flag_ff && !tclr);

	// ---------------------------------------------------------------
	// output generation
	// ---------------------------------------------------------------
	wire nxt_narrow_out = narrow_timer_run ? narrow_timer_level : !init8;
	wire nxt_wide_out = sub_force ? sub_fld[0] :
		lk.running ? wide_lvl_ff : !init16;
	wire combine_t comb_sel = combine_t'(logic_fld);
	wire both_and = narrow_out_ff && wide_out_ff;
	wire both_or = narrow_out_ff || wide_out_ff;
	wire comb_out = (comb_sel == COMB_AND) ? both_and :
		(comb_sel == COMB_OR) ? both_or :
		(comb_sel == COMB_NOR) ? !both_or : !both_and;
	wire nxt_pin = (xmit && pinsel) ? comb_out : port_out_ff;
	wire wide_toggle = xmit && sub_run && lk.timeout;
	wire nxt_irq = lk.timeout && wide_ctl_ff[`B_W_IE] && global_int_enable;

	// ping-pong runs while its code was last written in transmit mode
	wire pp_write = wr_shared && !wdata[`B_MODE];
	wire nxt_pingpong = pp_write ? (wdata[`B_SUB_HI:`B_SUB_LO] == `SUB_PINGPONG) :
		(pingpong_ff && xmit);

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	wire [7:0] shared_rd = {shared_ff[`B_MODE:`B_SUB_LO],
		demod ? rise_flag_ff : init8, demod ? fall_flag_ff : init16};
	wire [7:0] wide_rd = (wide_ctl_ff & `W_STORE_MASK) |
		({7'h00, lk.running} << `B_W_ENABLE) |
		({7'h00, timeout_flag_ff} << `B_W_FLAG);
	wire [7:0] rd_mux = (addr == `OFS_SHARED) ? shared_rd :
		(addr == `OFS_WIDE_CTL) ? wide_rd :
		(addr == `OFS_RELOAD_HI) ? reload_hi_ff :
		(addr == `OFS_RELOAD_LO) ? reload_lo_ff :
		(addr == `OFS_PORT_OUT) ? {7'h00, port_out_ff} : `RDATA_IDLE;
	wire [7:0] nxt_rdata = rd ? rd_mux : `RDATA_IDLE;

	// shared control: the initial-level bits are written only in transmit mode and keep their value in demodulation mode
	wire [7:0] nxt_shared = demod ?
		{wdata[`B_MODE:`B_SUB_LO], shared_ff[`B_INIT8:`B_INIT16]} : wdata;

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shared_ff <= `SHARED_RST;
			wide_ctl_ff <= `WIDE_RST;
			reload_hi_ff <= `RELOAD_RST;
			reload_lo_ff <= `RELOAD_RST;
			port_out_ff <= 1'b0;
		end else begin
			if (wr_shared) shared_ff <= nxt_shared;
			if (wr_wide) wide_ctl_ff <= wdata & `W_STORE_MASK;
			if (wr_hi) reload_hi_ff <= wdata;
			if (wr_lo) reload_lo_ff <= wdata;
			if (wr_port) port_out_ff <= wdata[`B_PORT];
		end
	end

	// event flags and edge history
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rise_flag_ff <= 1'b0;
			fall_flag_ff <= 1'b0;
			timeout_flag_ff <= 1'b0;
			prev_level_ff <= 1'b0;
		end else begin
			rise_flag_ff <= nxt_rise_flag;
			fall_flag_ff <= nxt_fall_flag;
			timeout_flag_ff <= nxt_timeout_flag;
			prev_level_ff <= lk.level;
		end
	end

	// wide timer running level and ping-pong state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wide_lvl_ff <= 1'b0;
			pingpong_ff <= 1'b0;
		end else begin
			if (lk.start) wide_lvl_ff <= init16;
			else if (wide_toggle) wide_lvl_ff <= !wide_lvl_ff;
			pingpong_ff <= nxt_pingpong;
		end
	end

	// registered outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= `RDATA_IDLE;
			pin_ff <= 1'b0;
			narrow_out_ff <= 1'b1;
			wide_out_ff <= 1'b1;
			irq_ff <= 1'b0;
			handoff_ff <= 1'b0;
			rise_ev_ff <= 1'b0;
			fall_ev_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			pin_ff <= nxt_pin;
			narrow_out_ff <= nxt_narrow_out;
			wide_out_ff <= nxt_wide_out;
			irq_ff <= nxt_irq;
			handoff_ff <= lk.timeout && pingpong_ff;
			rise_ev_ff <= rise_set;
			fall_ev_ff <= fall_set;
		end
	end

	assign rdata = rdata_ff;
	assign combined_output_pin = pin_ff;
	assign narrow_timer_output = narrow_out_ff;
	assign wide_timer_output = wide_out_ff;
	assign wide_timeout_irq = irq_ff;
	assign ping_pong_active = pingpong_ff;
	assign ping_pong_handoff = handoff_ff;
	assign demod_rise_event = rise_ev_ff;
	assign demod_fall_event = fall_ev_ff;
	assign demod_mode = demod;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_rise_seen;
		demod && rise_en && lvl_rise;
	endsequence
	sequence s_fall_clear;
		wr_shared && demod && wdata[`B_INIT16] && !fall_set;
	endsequence
	sequence s_enable_write;
		wr_wide && wdata[`B_W_ENABLE] && !lk.running;
	endsequence

	a_read_only_after: assert property (!rd |=> rdata == `RDATA_IDLE)
		else $error("read data outside its cycle");
	a_force_wide_low: assert property (xmit && sub_fld == `SUB_FORCE0 |=> !wide_timer_output)
		else $error("forced low not seen");
	a_idle_wide_level: assert property (xmit && sub_run && !lk.running
		|=> wide_timer_output == !$past(init16))
		else $error("idle wide level wrong");
	a_narrow_idle: assert property (!narrow_timer_run
		|=> narrow_timer_output == !$past(init8))
		else $error("idle narrow level wrong");
	a_port_pin: assert property (xmit && !pinsel |=> combined_output_pin == $past(port_out_ff))
		else $error("pin not port data");
	a_rise_flag_set: assert property (s_rise_seen |=> rise_flag_ff && rise_ev_ff ##1 !rise_ev_ff)
		else $error("rising edge flag missed");
	a_fall_flag_clr: assert property (s_fall_clear |=> !fall_flag_ff)
		else $error("falling flag not cleared");
	a_enable_loads: assert property (s_enable_write
		|=> lk.count == $past(lk.reload) && wide_lvl_ff == $past(init16))
		else $error("enable did not load");
	a_timeout_flag: assert property (lk.timeout |=> timeout_flag_ff)
		else $error("timeout flag missed");
	a_irq_gated: assert property (wide_timeout_irq |-> $past(global_int_enable))
		else $error("interrupt without global enable");
	a_pingpong_end: assert property (pp_write && wdata[`B_SUB_HI:`B_SUB_LO] == `SUB_NORMAL
		|=> !ping_pong_active)
		else $error("ping-pong not ended");
endmodule

// *** tb/pulse_pin_model.sv ***
// pin model that sends pulses into the demodulator input pins
`timescale 1ns/10ps
module pulse_pin_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic fire,
	input wire logic [7:0] width,
	input wire logic sel_alt,
	output logic comparator_demod_pin,
	output logic alternate_demod_pin
);
	logic [7:0] left_ff;
	logic noise_ff;
	logic level;
	// ---------------------------------------------------------------
	// pulse length counter and idle noise
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			left_ff <= 8'h00;
			noise_ff <= 1'b0;
		end else begin
			noise_ff <= ~noise_ff;
			left_ff <= fire ? width : (left_ff != 8'h00) ? left_ff - 8'h01 : 8'h00;
		end
	end
	assign level = (left_ff != 8'h00);
	// pulse on the chosen pin; the unused pin toggles so a wrong route shows
	assign comparator_demod_pin = sel_alt ? noise_ff : level;
	assign alternate_demod_pin = sel_alt ? level : noise_ff;
endmodule

// *** tb/test_pulse_timer_common_control.sv ***
// self-checking bench for the pulse timer shared control
`timescale 1ns/10ps
module test_pulse_timer_common_control;
	logic clk, resetn, wr, rd, narrow_timer_run, narrow_timer_level, global_int_enable;
	logic comparator_demod_pin, alternate_demod_pin, combined_output_pin, narrow_timer_output;
	logic wide_timer_output, wide_timeout_irq, ping_pong_active, ping_pong_handoff;
	logic demod_rise_event, demod_fall_event, demod_mode, fire, sel_alt;
	logic [7:0] addr, wdata, rdata, width, cfg;
	int miscompares, cmp_count, cyc, since, gap, n, irqs, k, rises, falls, hands;
	// demod cases: shared config, pulse width, expected flags
	logic [23:0] tc [9] = '{24'hE00503, 24'hD00502, 24'hC00501, 24'hF00500, 24'hE40300,
		24'hE40603, 24'hE80600, 24'hE80C03, 24'hA00503};

	pulse_timer_common_control pulse_timer_common_control_inst (
		.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .narrow_timer_run,
		.narrow_timer_level, .comparator_demod_pin, .alternate_demod_pin,
		.global_int_enable, .combined_output_pin, .narrow_timer_output,
		.wide_timer_output, .wide_timeout_irq, .ping_pong_active, .ping_pong_handoff,
		.demod_rise_event, .demod_fall_event, .demod_mode);
	pulse_pin_model pulse_pin_model_inst (
		.clk, .resetn, .fire, .width, .sel_alt, .comparator_demod_pin, .alternate_demod_pin);

	// clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// timeout gaps, pulse count and hang limit
	always @(negedge clk) begin
		cyc++;
		since++;
		if (wide_timeout_irq === 1'b1) begin
			gap = since;
			since = 0;
			irqs++;
		end
		// event pulses, one cycle each, counted mid-cycle
		if (demod_rise_event === 1'b1) rises++;
		if (demod_fall_event === 1'b1) falls++;
		if (ping_pong_handoff === 1'b1) hands++;
		if (cyc == 5000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: saw %h, wanted %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	task automatic settle;
		repeat (3) @(negedge clk);
	endtask
	task automatic next_irq;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (wide_timeout_irq !== 1'b1 && n < 400);
		chk(wide_timeout_irq, 1'b1);
		@(negedge clk);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// stimulus
	// ---------------------------------------------------------------
	initial begin
		{resetn, wr, rd, fire, sel_alt, narrow_timer_run, narrow_timer_level} = '0;
		addr = 8'h00;
		wdata = 8'h00;
		width = 8'h00;
		global_int_enable = 1'b1;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk({narrow_timer_output, wide_timer_output, combined_output_pin, demod_mode}, 4'hC);
		rchk(8'h01, 8'h00);
		rchk(8'h02, 8'h00);
		wreg(8'h10, 8'hFF);
		rchk(8'h10, 8'h00);
		wreg(8'h01, 8'h03);
		settle();
		chk({narrow_timer_output, wide_timer_output}, 2'h0);
		rchk(8'h01, 8'h03);
		wreg(8'h05, 8'h01);
		settle();
		chk(combined_output_pin, 1'b1);
		// every logic code against both levels of each timer output
		narrow_timer_run <= 1'b1;
		for (int c = 0; c < 16; c++) begin
			wreg(8'h01, {2'b01, c[3:2], 1'b1, c[1], 2'b00});
			narrow_timer_level <= c[0];
			settle();
			chk(wide_timer_output, c[1]);
			chk(combined_output_pin, ((c[2] ^ c[3]) ? c[0] | c[1] : c[0] & c[1]) ^ c[3]);
		end
		wreg(8'h01, 8'h04);
		settle();
		chk(ping_pong_active, 1'b1);
		wreg(8'h01, 8'h00);
		narrow_timer_run <= 1'b0;
		settle();
		chk({ping_pong_active, narrow_timer_output}, 2'h1);
		// single pass from reload six
		wreg(8'h01, 8'h01);
		wreg(8'h03, 8'h00);
		wreg(8'h04, 8'h06);
		settle();
		chk(wide_timer_output, 1'b0);
		wreg(8'h02, 8'h83);
		settle();
		chk(wide_timer_output, 1'b1);
		next_irq();
		chk(wide_timer_output, 1'b0);
		rchk(8'h02, 8'h23);
		wreg(8'h02, 8'h20);
		rchk(8'h02, 8'h00);
		// modulo-N, reload changed while counting
		wreg(8'h04, 8'h07);
		wreg(8'h02, 8'h82);
		next_irq();
		wreg(8'h04, 8'h09);
		next_irq();
		chk(gap, 7);
		next_irq();
		chk(gap, 9);
		// ping-pong hands over at each timeout, normal operation does not
		chk(hands, 0);
		wreg(8'h01, 8'h05);
		next_irq();
		chk(hands, 1);
		wreg(8'h01, 8'h01);
		wreg(8'h02, 8'hA6);
		global_int_enable <= 1'b0;
		k = irqs;
		repeat (60) @(posedge clk);
		chk(irqs, k);
		rchk(8'h02, 8'hA6);
		wreg(8'h02, 8'hA6);
		global_int_enable <= 1'b1;
		next_irq();
		next_irq();
		chk(gap, 18);
		wreg(8'h02, 8'h00);
		k = irqs;
		repeat (60) @(posedge clk);
		chk(irqs, k);
		// demodulation cases, both timers already stopped
		for (int i = 0; i < 9; i++) begin
			cfg = tc[i][23:16];
			wreg(8'h01, cfg | 8'h03);
			sel_alt <= cfg[6];
			repeat (10) @(posedge clk);
			wreg(8'h01, cfg | 8'h03);
			rises = 0;
			falls = 0;
			fire <= 1'b1;
			width <= tc[i][15:8];
			@(posedge clk);
			fire <= 1'b0;
			repeat (40) @(posedge clk);
			chk(demod_mode, 1'b1);
			rchk(8'h01, cfg | tc[i][7:0]);
			chk(rises, tc[i][1]);
			chk(falls, tc[i][0]);
		end
		wreg(8'h01, 8'hA1);
		rchk(8'h01, 8'hA2);
		wreg(8'h01, 8'hA0);
		rchk(8'h01, 8'hA2);
		wreg(8'h01, 8'hA2);
		rchk(8'h01, 8'hA0);
		report_and_stop();
	end
endmodule
